// *** core/conv_device.sv ***
`timescale 1ns/10ps
`include "conv_defines.svh"
// Contract
// - Conversion synchronous, done within two periods.
// - Each sample yields one ten-bit code.
// - Clock high balances, low samples, rise ends.
// - Sampling instant lags rise by aperture delay.
// - Coarse picks subrange; fine resolves lower bits.
// - Separate overflow flag; data bits unaffected.
// - Overflow above top minus half LSB.
// - Out-of-range inputs clamp to zero/full scale.
// - Ladder snapshot serves two adjacent conversions.
// - Controller discards one result on ladder jump.
// - Discarded sample may use 150 ns low.
// - Any duty cycle within timing limits.
// - Continuous or on-demand clock; idle balanced.
// - Write strobe low latches channel address.
// - Power down freezes outputs, disconnects lower reference.
// - Two flip-flops between encoder and pins.
module conv_device
  import conv_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  conv_link_if.dev link,
  input wire logic [`LEVEL_W-1:0] analog_input [`CHAN_N],
  output logic ladder_lo_connected
);
  // ********************
  // Pin synchronisation
  // ********************
  localparam int PIN_W = 5 + `LEVEL_W;
  localparam logic [PIN_W-1:0] PIN_IDLE = {2'b11, {(PIN_W - 2){1'b0}}};

  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins_s;
  logic clk_s;
  logic wr_n_s;
  logic sel_hi_s;
  logic sel_lo_s;
  logic sleep_s;
  level_t ladder_s;

  // Every pin from the controller is brought onto sys_clk first.
  assign pins_raw = {link.conv_clk, link.wr_n, link.channel_select_hi,
                     link.channel_select_lo, link.power_down_input, link.ladder_level};

  conv_sync #(
    .W(PIN_W),
    .RST(PIN_IDLE)
  ) u_pin_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .d(pins_raw),
    .q(pins_s)
  );

  assign {clk_s, wr_n_s, sel_hi_s, sel_lo_s, sleep_s, ladder_s} = pins_s;

  // Each analog level is brought onto sys_clk before the comparators see it.
  level_t lvl_s [`CHAN_N];
  for (genvar c = 0; c < `CHAN_N; c++) begin : g_in_sync
    conv_sync #(
      .W(`LEVEL_W),
      .RST('0)
    ) u_in_sync (
      .sys_clk(sys_clk),
      .srst(srst),
      .d(analog_input[c]),
      .q(lvl_s[c])
    );
  end

  // ********************
  // State
  // ********************
  logic clk_d_reg;
  logic clk_d_next;
  logic [2:0] ap_reg;
  logic [2:0] ap_next;
  logic [1:0] chan_reg;
  logic [1:0] chan_next;
  level_t vin_reg;
  level_t vin_next;
  logic [3:0] coarse_reg;
  logic [3:0] coarse_next;
  code_t s1_code_reg;
  code_t s1_code_next;
  logic s1_ovf_reg;
  logic s1_ovf_next;
  code_t out_code_reg;
  code_t out_code_next;
  logic out_ovf_reg;
  logic out_ovf_next;
  logic [4:0] pu_reg;
  logic [4:0] pu_next;
  logic conn_reg;
  logic conn_next;

  logic rise;
  logic strobe;
  logic freeze;
  level_t vin_sel;
  diff_t diff_in;
  logic [`COARSE_N-1:0] crs_cmp;
  logic [3:0] crs_count;
  logic [`CODE_W:0] resolved;

  // ********************
  // Resolution of one sample
  // ********************
  // Fine step: converts against the ladder as it stands now and keeps
  // the result inside the subrange that the coarse pass picked.
  function automatic logic [`CODE_W:0] resolve(
    input level_t vin,
    input level_t lad,
    input logic [3:0] crs
  );
    diff_t a;
    diff_t half;
    logic [10:0] full;
    logic [10:0] base;
    logic [10:0] fine;
    a = diff_t'({1'b0, vin}) - diff_t'({1'b0, lad});
    half = (a + `STEP_FIRST) >>> 1;
    if (a < `STEP_FIRST) begin
      full = 11'h000;
    end else if (a >= `STEP_LAST) begin
      full = `CODE_FULL;
    end else begin
      full = half[10:0];
    end
    base = {1'b0, crs, 6'h00};
    if (full < base) begin
      fine = 11'h000;
    end else if ((full - base) > `FINE_MAX) begin
      fine = `FINE_MAX;
    end else begin
      fine = full - base;
    end
    resolve = {(a >= `OVF_STEP), crs, fine[5:0]};
  endfunction : resolve

  // ********************
  // Clock phases and aperture
  // ********************
  // A rise of the conversion clock ends the sample phase; the input is
  // taken a fixed aperture later, while the clock is high (balance).
  assign rise = clk_s & ~clk_d_reg;
  assign strobe = (ap_reg == 3'h1);
  assign freeze = sleep_s | (pu_reg != 5'h00);

  // ********************
  // Input multiplexer and coarse pass
  // ********************
  assign vin_sel = lvl_s[chan_reg];
  assign diff_in = diff_t'({1'b0, vin_sel}) - diff_t'({1'b0, ladder_s});

  // One comparator per coarse ladder tap.
  for (genvar i = 0; i < `COARSE_N; i++) begin : g_coarse
    assign crs_cmp[i] = (diff_in >= diff_t'((i + 1) * `COARSE_STEP - 1));
  end

  // Thermometer to binary subrange number.
  always_comb begin
    crs_count = 4'h0;
    for (int k = 0; k < `COARSE_N; k++) begin
      crs_count = crs_count + {3'h0, crs_cmp[k]};
    end
  end

  // The latest ladder snapshot finishes the previous sample.
  assign resolved = resolve(vin_reg, ladder_s, coarse_reg);

  // ********************
  // Next-state logic
  // ********************
  // Sample and pipeline registers advance once per sample strobe; the rest every cycle.
  always_comb begin
    clk_d_next = clk_s;
    ap_next = ap_reg;
    chan_next = chan_reg;
    vin_next = vin_reg;
    coarse_next = coarse_reg;
    s1_code_next = s1_code_reg;
    s1_ovf_next = s1_ovf_reg;
    out_code_next = out_code_reg;
    out_ovf_next = out_ovf_reg;
    pu_next = pu_reg;
    conn_next = ~sleep_s;
    // Channel address passes while the write strobe is low.
    if (!wr_n_s) begin
      chan_next = {sel_hi_s, sel_lo_s};
    end
    // Aperture count starts at every rise, idles at zero.
    if (rise) begin
      ap_next = 3'(`AP_CYC);
    end else if (ap_reg != 3'h0) begin
      ap_next = ap_reg - 3'h1;
    end
    // Leaving power down waits for the power-up time.
    if (sleep_s) begin
      pu_next = 5'(`PU_CYC);
    end else if (pu_reg != 5'h00) begin
      pu_next = pu_reg - 5'h01;
    end
    if (strobe) begin
      // Take the new sample and its coarse subrange.
      vin_next = vin_sel;
      coarse_next = crs_count;
      // Previous sample enters the first pipeline stage.
      s1_code_next = resolved[`CODE_W-1:0];
      s1_ovf_next = resolved[`CODE_W];
      // Second stage drives the pins unless frozen.
      if (!freeze) begin
        out_code_next = s1_code_reg;
        out_ovf_next = s1_ovf_reg;
      end
    end
  end

  // ********************
  // Registers
  // ********************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      clk_d_reg <= 1'b1;
      ap_reg <= 3'h0;
      chan_reg <= 2'h0;
      vin_reg <= '0;
      coarse_reg <= 4'h0;
      s1_code_reg <= '0;
      s1_ovf_reg <= 1'b0;
      out_code_reg <= '0;
      out_ovf_reg <= 1'b0;
      pu_reg <= 5'h00;
      conn_reg <= 1'b1;
    end else begin
      clk_d_reg <= clk_d_next;
      ap_reg <= ap_next;
      chan_reg <= chan_next;
      vin_reg <= vin_next;
      coarse_reg <= coarse_next;
      s1_code_reg <= s1_code_next;
      s1_ovf_reg <= s1_ovf_next;
      out_code_reg <= out_code_next;
      out_ovf_reg <= out_ovf_next;
      pu_reg <= pu_next;
      conn_reg <= conn_next;
    end
  end

  // ********************
  // Outputs
  // ********************
  // Pins come straight from the second pipeline stage.
  assign link.conversion_result = out_code_reg;
  assign link.overflow_flag = out_ovf_reg;
  assign ladder_lo_connected = conn_reg;
endmodule : conv_device

// *** core/conv_host.sv ***
`timescale 1ns/10ps
`include "conv_defines.svh"
// Controller: makes the conversion clock, drives address, ladder and
// power down, and hands results to software over APB.
module conv_host
  import conv_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  conv_link_if.host link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq
);
  logic [`CODE_W:0] res_s;
  ck_state_e ck_state_reg, ck_state_next;
  logic [6:0] ck_cnt_reg, ck_cnt_next;
  logic [6:0] low_len_reg, low_len_next;
  logic conv_clk_reg, conv_clk_next;
  logic [1:0] ctrl_reg, ctrl_next;
  logic req_reg, req_next;
  logic [1:0] chan_reg, chan_next;
  logic [2:0] wr_cnt_reg, wr_cnt_next;
  logic wr_n_reg, wr_n_next;
  level_t lad_out_reg, lad_out_next;
  level_t lad_new_reg, lad_new_next;
  logic lad_pend_reg, lad_pend_next;
  logic lad_arm_reg, lad_arm_next;
  logic disc_reg, disc_next;
  tag_s tag_reg [3];
  tag_s tag_next [3];
  logic [`CODE_W:0] result_reg, result_next;
  logic [2:0] status_reg, status_next;
  logic [2:0] irq_en_reg, irq_en_next;
  logic [31:0] prdata_next;
  logic [2:0] set;
  logic [2:0] clr;
  logic rise;
  logic big;
  diff_t lad_delta;

  // ********************
  // Result pins
  // ********************
  conv_sync #(
    .W(`CODE_W + 1),
    .RST('0)
  ) u_res_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .d({link.overflow_flag, link.conversion_result}),
    .q(res_s)
  );

  // Zero-wait slave: answer in the first access cycle.
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign irq = |(status_reg & irq_en_reg);
  assign lad_delta = diff_t'({1'b0, lad_new_reg}) - diff_t'({1'b0, lad_out_reg});
  assign big = (lad_delta > `LADDER_TOL) || (lad_delta < -`LADDER_TOL);

  // ********************
  // Next-state logic
  // ********************
  always_comb begin
    ck_state_next = ck_state_reg;
    ck_cnt_next = ck_cnt_reg;
    low_len_next = low_len_reg;
    conv_clk_next = conv_clk_reg;
    ctrl_next = ctrl_reg;
    req_next = req_reg;
    chan_next = chan_reg;
    wr_cnt_next = wr_cnt_reg;
    lad_out_next = lad_out_reg;
    lad_new_next = lad_new_reg;
    lad_pend_next = lad_pend_reg;
    lad_arm_next = lad_arm_reg;
    disc_next = disc_reg;
    tag_next = tag_reg;
    result_next = result_reg;
    irq_en_next = irq_en_reg;
    prdata_next = prdata;
    set = 3'h0;
    clr = 3'h0;
    rise = 1'b0;
    // Clock generator; idles high so the converter stays balanced.
    case (ck_state_reg)
      CK_HIGH: begin
        if (ck_cnt_reg != 7'h7f) begin
          ck_cnt_next = ck_cnt_reg + 7'h01;
        end
        // New ladder level goes out only after the aperture has passed.
        if (lad_arm_reg && ck_cnt_reg == 7'(`APPLY_CYC)) begin
          lad_out_next = lad_new_reg;
          lad_arm_next = 1'b0;
        end
        if (ck_cnt_reg >= 7'(`HIGH_CYC - 1) && !lad_arm_reg
            && (ctrl_reg[`CTRL_RUN] || req_reg)) begin
          ck_state_next = CK_LOW;
          ck_cnt_next = 7'h00;
          conv_clk_next = 1'b0;
          req_next = 1'b0;
          lad_arm_next = lad_pend_reg;
          lad_pend_next = 1'b0;
          disc_next = lad_pend_reg & big;
          low_len_next = (lad_pend_reg & big) ? 7'(`LOW_SHORT_CYC) : 7'(`LOW_CYC);
        end
      end
      CK_LOW: begin
        ck_cnt_next = ck_cnt_reg + 7'h01;
        if (ck_cnt_reg == low_len_reg - 7'h01) begin
          ck_state_next = CK_HIGH;
          ck_cnt_next = 7'h00;
          conv_clk_next = 1'b1;
          rise = 1'b1;
        end
      end
      default: begin
        ck_state_next = CK_HIGH;
      end
    endcase
    // At each rise the pins show the sample of three rises back.
    if (rise) begin
      tag_next[0] = '{valid: ~ctrl_reg[`CTRL_SLEEP], discard: disc_reg};
      tag_next[1] = tag_reg[0];
      tag_next[2] = tag_reg[1];
      if (tag_reg[2].valid && !ctrl_reg[`CTRL_SLEEP]) begin
        if (tag_reg[2].discard) begin
          set[`ST_DISC] = 1'b1;
        end else begin
          result_next = res_s;
          set[`ST_DONE] = 1'b1;
          set[`ST_OVF] = res_s[`CODE_W];
        end
      end
    end
    // Write strobe pulse holds the address.
    if (wr_cnt_reg != 3'h0) begin
      wr_cnt_next = wr_cnt_reg - 3'h1;
    end
    // Register writes at the access edge.
    if (psel && penable && pwrite) begin
      case (paddr)
        `REG_CTRL: ctrl_next = pwdata[1:0];
        `REG_CMD: req_next = req_next | pwdata[0];
        `REG_CHAN: begin
          chan_next = pwdata[1:0];
          wr_cnt_next = 3'(`WR_CYC);
        end
        `REG_LADDER: begin
          lad_new_next = pwdata[`LEVEL_W-1:0];
          lad_pend_next = 1'b1;
        end
        `REG_CLEAR: clr = pwdata[2:0];
        `REG_IRQ_EN: irq_en_next = pwdata[2:0];
        default: ;
      endcase
    end
    // Read data is fetched in the setup cycle.
    if (psel && !penable) begin
      case (paddr)
        `REG_CTRL: prdata_next = {30'h0, ctrl_reg};
        `REG_CHAN: prdata_next = {30'h0, chan_reg};
        `REG_LADDER: prdata_next = {19'h0, lad_new_reg};
        `REG_RESULT: prdata_next = {21'h0, result_reg};
        `REG_STATUS: prdata_next = {29'h0, status_reg};
        `REG_IRQ_EN: prdata_next = {29'h0, irq_en_reg};
        default: prdata_next = 32'h0;
      endcase
    end
    wr_n_next = (wr_cnt_next == 3'h0);
    // A new event wins over a clear in the same cycle.
    status_next = (status_reg & ~clr) | set;
  end

  // ********************
  // Registers
  // ********************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ck_state_reg <= CK_HIGH;
      ck_cnt_reg <= 7'h00;
      low_len_reg <= 7'(`LOW_CYC);
      conv_clk_reg <= 1'b1;
      ctrl_reg <= 2'h0;
      req_reg <= 1'b0;
      chan_reg <= 2'h0;
      wr_cnt_reg <= 3'h0;
      wr_n_reg <= 1'b1;
      lad_out_reg <= '0;
      lad_new_reg <= '0;
      lad_pend_reg <= 1'b0;
      lad_arm_reg <= 1'b0;
      disc_reg <= 1'b0;
      tag_reg <= '{default: '0};
      result_reg <= '0;
      status_reg <= 3'h0;
      irq_en_reg <= 3'h0;
      prdata <= 32'h0;
    end else begin
      ck_state_reg <= ck_state_next;
      ck_cnt_reg <= ck_cnt_next;
      low_len_reg <= low_len_next;
      conv_clk_reg <= conv_clk_next;
      ctrl_reg <= ctrl_next;
      req_reg <= req_next;
      chan_reg <= chan_next;
      wr_cnt_reg <= wr_cnt_next;
      wr_n_reg <= wr_n_next;
      lad_out_reg <= lad_out_next;
      lad_new_reg <= lad_new_next;
      lad_pend_reg <= lad_pend_next;
      lad_arm_reg <= lad_arm_next;
      disc_reg <= disc_next;
      tag_reg <= tag_next;
      result_reg <= result_next;
      status_reg <= status_next;
      irq_en_reg <= irq_en_next;
      prdata <= prdata_next;
    end
  end

  assign link.conv_clk = conv_clk_reg;
  assign link.wr_n = wr_n_reg;
  assign link.channel_select_hi = chan_reg[1];
  assign link.channel_select_lo = chan_reg[0];
  assign link.power_down_input = ctrl_reg[`CTRL_SLEEP];
  assign link.ladder_level = lad_out_reg;
endmodule : conv_host

// *** core/conv_sync.sv ***
`timescale 1ns/10ps
// Two flip-flops in a row for levels arriving from the far end.
module conv_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_next;

  // The first stage feeds only the second.
  always_comb begin
    meta_next = d;
    q_next = meta_reg;
  end

  // Both stages take the idle level under reset.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta_reg <= RST;
      q <= RST;
    end else begin
      meta_reg <= meta_next;
      q <= q_next;
    end
  end
endmodule : conv_sync

// *** inc/conv_defines.svh ***
`ifndef CONV_DEFINES_SVH
`define CONV_DEFINES_SVH
// ********************
// Widths
// ********************
`define CODE_W 10
`define LEVEL_W 13
`define CHAN_N 4
`define COARSE_N 15
`define COARSE_STEP 128
// ********************
// Transfer points, in half-LSB units
// ********************
`define STEP_FIRST 14'sd1
`define STEP_LAST 14'sd2045
`define OVF_STEP 14'sd2047
`define CODE_FULL 11'h3ff
`define FINE_MAX 11'h03f
`define LADDER_TOL 14'sd2
// ********************
// Timing
// ********************
`define SYS_CLK_NS 10
`define AP_NS 35
`define AP_CYC ((`AP_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
`define PU_NS 200
`define PU_CYC ((`PU_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
`define HIGH_NS 250
`define HIGH_CYC ((`HIGH_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
`define PERIOD_NS 1000
`define LOW_CYC ((`PERIOD_NS - `HIGH_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
`define LOW_MIN_NS 150
`define LOW_SHORT_CYC ((`LOW_MIN_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
`define WR_NS 40
`define WR_CYC ((`WR_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
`define APPLY_CYC 12
// ********************
// Controller register map
// ********************
`define REG_CTRL 8'h00
`define REG_CMD 8'h04
`define REG_CHAN 8'h08
`define REG_LADDER 8'h0c
`define REG_RESULT 8'h10
`define REG_STATUS 8'h14
`define REG_CLEAR 8'h18
`define REG_IRQ_EN 8'h1c
`define CTRL_RUN 0
`define CTRL_SLEEP 1
`define ST_DONE 0
`define ST_OVF 1
`define ST_DISC 2
`endif

// *** inc/conv_link_if.sv ***
`timescale 1ns/10ps
`include "conv_defines.svh"
// Pins between the converter and its controller.
interface conv_link_if;
  logic conv_clk;
  logic wr_n;
  logic channel_select_hi;
  logic channel_select_lo;
  logic power_down_input;
  logic [`LEVEL_W-1:0] ladder_level;
  logic [`CODE_W-1:0] conversion_result;
  logic overflow_flag;
  modport dev (
    input conv_clk, wr_n, channel_select_hi, channel_select_lo, power_down_input, ladder_level,
    output conversion_result, overflow_flag
  );
  modport host (
    output conv_clk, wr_n, channel_select_hi, channel_select_lo, power_down_input, ladder_level,
    input conversion_result, overflow_flag
  );
endinterface : conv_link_if

// *** inc/conv_pkg.sv ***
`include "conv_defines.svh"
package conv_pkg;
  // Phase of the conversion clock made by the controller.
  typedef enum logic [0:0] {CK_HIGH = 1'b0, CK_LOW = 1'b1} ck_state_e;
  typedef logic signed [`LEVEL_W:0] diff_t;
  typedef logic [`LEVEL_W-1:0] level_t;
  typedef logic [`CODE_W-1:0] code_t;
  // Bookkeeping for one clock pulse travelling through the pipeline.
  typedef struct packed {
    logic valid;
    logic discard;
  } tag_s;
endpackage : conv_pkg

// *** verification/conv_link_chk.sv ***
`timescale 1ns/10ps
`include "conv_defines.svh"
// ********************
// Link checker
// ********************
module conv_link_chk (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic conv_clk,
  input wire logic wr_n,
  input wire logic channel_select_hi,
  input wire logic channel_select_lo,
  input wire logic power_down_input,
  input wire logic [`LEVEL_W-1:0] ladder_level,
  input wire logic [`CODE_W-1:0] conversion_result,
  input wire logic overflow_flag
);
  logic [7:0] hi_cnt_reg, hi_cnt_next, lo_cnt_reg, lo_cnt_next;
  logic [7:0] since_rise_reg, since_rise_next;
  logic clk_q_reg, clk_q_next;

  // Counts high and low samples of the conversion clock and cycles since its rise.
  always_comb begin
    hi_cnt_next = !conv_clk ? 8'h00 : (hi_cnt_reg == 8'hff) ? hi_cnt_reg : hi_cnt_reg + 8'h01;
    lo_cnt_next = conv_clk ? 8'h00 : (lo_cnt_reg == 8'hff) ? lo_cnt_reg : lo_cnt_reg + 8'h01;
    since_rise_next = (since_rise_reg == 8'hff) ? since_rise_reg : since_rise_reg + 8'h01;
    if (conv_clk && !clk_q_reg) begin
      since_rise_next = 8'h01;
    end
    clk_q_next = conv_clk;
  end

  // Registers the counters; reset leaves the clock idle high.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      hi_cnt_reg <= 8'h00;
      lo_cnt_reg <= 8'h00;
      since_rise_reg <= 8'hff;
      clk_q_reg <= 1'h1;
    end else begin
      hi_cnt_reg <= hi_cnt_next;
      lo_cnt_reg <= lo_cnt_next;
      since_rise_reg <= since_rise_next;
      clk_q_reg <= clk_q_next;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  // ********************
  // Assertions
  // ********************
  a_high_min:
    assert property ($fell(conv_clk) |-> hi_cnt_reg >= 8'h19)
    else $error("conversion clock high phase too short");
  a_low_len:
    assert property ($rose(conv_clk) |-> (lo_cnt_reg == 8'h4b || lo_cnt_reg == 8'h0f))
    else $error("conversion clock low phase has wrong length");
  a_result_time:
    assert property (($changed(conversion_result) || $changed(overflow_flag))
      |-> since_rise_reg inside {[8'h04:8'h0c]})
    else $error("result changed away from the sampling strobe");
  a_sleep_freeze:
    assert property (power_down_input [*5] |=> $stable(conversion_result))
    else $error("result moved during power down");
  a_wr_pulse:
    assert property ($fell(wr_n) |-> !wr_n [*4] ##1 wr_n)
    else $error("write strobe width wrong");
  a_sel_hold:
    assert property (!wr_n ##1 1'h1 |-> $stable({channel_select_hi, channel_select_lo}))
    else $error("channel select moved around the write strobe");
  a_ladder_high:
    assert property ($changed(ladder_level) |-> conv_clk && hi_cnt_reg inside {[8'h01:8'h18]})
    else $error("ladder changed outside the balance phase");
  a_ovf_full:
    assert property (overflow_flag |-> conversion_result == 10'h3ff)
    else $error("overflow without full scale code");

  // Main scenarios reached.
  c_short_low: cover property ($rose(conv_clk) && lo_cnt_reg == 8'h0f);
  c_overflow: cover property (overflow_flag);
  c_sleep_exit: cover property (power_down_input ##1 !power_down_input);
endmodule : conv_link_chk

// *** verification/test_two_step_adc_conversion_timing.sv ***
`timescale 1ns/10ps
`include "conv_defines.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %0t got %0h want %0h", $time, g, e); end end
module test_two_step_adc_conversion_timing;
  logic sys_clk, srst, psel, penable, pwrite, pready, pslverr, irq, lo_conn, clk_q;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [`LEVEL_W-1:0] lvl [`CHAN_N];
  logic [`CODE_W-1:0] r;
  logic [10:0] e;
  int mismatches, checked, rises, n0, vin, lad, ch;
  int offs[9] = '{-5, 0, 1, 2, 2044, 2045, 2046, 2047, 3000};

  // ********************
  // Design and checker
  // ********************
  conv_link_if conv_link_if_i ();
  conv_device conv_device_i (.sys_clk(sys_clk), .srst(srst), .link(conv_link_if_i),
    .analog_input(lvl), .ladder_lo_connected(lo_conn));
  conv_host conv_host_i (.sys_clk(sys_clk), .srst(srst), .link(conv_link_if_i),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
  conv_link_chk conv_link_chk_i (.sys_clk(sys_clk), .srst(srst),
    .conv_clk(conv_link_if_i.conv_clk), .wr_n(conv_link_if_i.wr_n),
    .channel_select_hi(conv_link_if_i.channel_select_hi),
    .channel_select_lo(conv_link_if_i.channel_select_lo),
    .power_down_input(conv_link_if_i.power_down_input),
    .ladder_level(conv_link_if_i.ladder_level),
    .conversion_result(conv_link_if_i.conversion_result),
    .overflow_flag(conv_link_if_i.overflow_flag));

  // Makes the clock and counts conversion clock rises.
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    clk_q <= conv_link_if_i.conv_clk;
    if (conv_link_if_i.conv_clk === 1'h1 && clk_q === 1'h0) rises++;
  end

  // ********************
  // Helpers
  // ********************
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc

  // One APB transfer; read data lands in q.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) begin
      mismatches++;
      complete_run();
    end
    q = prdata;
    `CHK(pslverr, 1'h0)
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge sys_clk);
  endtask : apb

  // Expected overflow bit and code for an input over a ladder, in half-LSB units.
  function automatic logic [10:0] exp_f(input int v, input int l);
    int a;
    a = v - l;
    exp_f[10] = a >= 2047;
    exp_f[9:0] = a < 1 ? 10'h000 : a >= 2045 ? 10'h3ff : 10'((a + 1) / 2);
  endfunction : exp_f

  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run

  // ********************
  // Main sequence
  // ********************
  initial begin
    sys_clk = 0;
    srst = 1;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    clk_q = 1;
    rises = 0;
    mismatches = 0;
    checked = 0;
    lad = 100;
    foreach (lvl[i]) lvl[i] = '0;
    void'($urandom(56));
    cyc(6);
    srst <= 1'h0;
    @(posedge sys_clk);
    // Idle levels after reset and an unmapped read.
    apb(0, `REG_RESULT, 0);
    `CHK(q, 32'h0)
    apb(0, 8'h40, 0);
    `CHK(q, 32'h0)
    `CHK(conv_link_if_i.conv_clk, 1'h1)
    `CHK(lo_conn, 1'h1)
    done("reset");
    // Ladder jump first, then corner and random inputs over all channels.
    apb(1, `REG_LADDER, lad);
    apb(1, `REG_CTRL, 1);
    for (int i = 0; i < 14; i++) begin
      vin = lad + (i < 9 ? offs[i] : $urandom_range(2100) - 5);
      ch = i % 4;
      foreach (lvl[k]) lvl[k] <= (k == ch) ? 13'(vin) : 13'($urandom_range(8191));
      apb(1, `REG_CHAN, ch);
      cyc(600);
      e = exp_f(vin, lad);
      apb(0, `REG_RESULT, 0);
      `CHK(q[10:0], e)
      `CHK(conv_link_if_i.conversion_result, e[9:0])
      `CHK(conv_link_if_i.overflow_flag, e[10])
    end
    apb(0, `REG_LADDER, 0);
    `CHK(q, lad)
    apb(0, `REG_CHAN, 0);
    `CHK(q, 1)
    apb(0, `REG_STATUS, 0);
    `CHK(q[2:0], 3'h7)
    apb(1, `REG_IRQ_EN, 32'h4);
    `CHK(irq, 1'h1)
    apb(1, `REG_IRQ_EN, 32'h0);
    `CHK(irq, 1'h0)
    apb(1, `REG_CTRL, 0);
    cyc(200);
    apb(1, `REG_CLEAR, 32'h7);
    apb(0, `REG_STATUS, 0);
    `CHK(q, 32'h0)
    apb(1, `REG_IRQ_EN, 32'h7);
    `CHK(irq, 1'h0)
    done("codes");
    // Power down holds the pins while the input moves.
    lvl[0] <= 13'(lad + 600);
    apb(1, `REG_CHAN, 0);
    apb(1, `REG_CTRL, 1);
    cyc(600);
    apb(1, `REG_CTRL, 3);
    cyc(300);
    r = conv_link_if_i.conversion_result;
    `CHK(lo_conn, 1'h0)
    lvl[0] <= 13'(lad + 1200);
    cyc(400);
    `CHK(conv_link_if_i.conversion_result, r)
    apb(1, `REG_CTRL, 1);
    cyc(600);
    e = exp_f(lad + 1200, lad);
    `CHK(lo_conn, 1'h1)
    `CHK(conv_link_if_i.conversion_result, e[9:0])
    done("power_down");
    // Pulses on demand: one rise per command, result after the third.
    apb(1, `REG_CTRL, 0);
    cyc(200);
    vin = lad + 333;
    lvl[0] <= 13'(vin);
    cyc(20);
    // A ladder write with no step must not tag its sample as discarded.
    apb(1, `REG_LADDER, lad);
    n0 = rises;
    repeat (3) begin
      apb(1, `REG_CMD, 1);
      cyc(150);
      `CHK(conv_link_if_i.conv_clk, 1'h1)
    end
    `CHK(rises - n0, 3)
    e = exp_f(vin, lad);
    `CHK(conv_link_if_i.conversion_result, e[9:0])
    apb(0, `REG_STATUS, 0);
    `CHK(q[2:0], 3'h1)
    apb(0, `REG_RESULT, 0);
    `CHK(q[10:0], exp_f(lad + 1200, lad))
    done("on_demand");
    complete_run();
  end
endmodule : test_two_step_adc_conversion_timing
